// [rtl/qld_ctrl.sv]
// Purpose: Control and diagnostics of a four channel low-side driver.
// Assumes: Serial clock idles low while chip select moves; pins are async.
// Notes: Serial logic runs on sclk, mode logic on clk.
`timescale 1ns/10ps
module qld_ctrl #(
   parameter int OVL_FILT_CYC = qld_pkg::OVL_FILT_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic csb_n,
   input wire logic si,
   output logic so,
   output logic so_oe_n,
   input wire logic limp_home_input,
   input wire logic enable,
   input wire logic logic_por,
   input wire logic analog_por,
   input wire logic [qld_pkg::CH-1:0] parallel_drive_inputs,
   input wire logic [qld_pkg::CH-1:0] overload_det,
   input wire logic [qld_pkg::CH-1:0] overtemp_det,
   input wire logic [qld_pkg::CH-1:0] open_load_det,
   output logic [qld_pkg::CH-1:0] driver_outputs,
   output logic [qld_pkg::CH-1:0] diag_current_en,
   output qld_pkg::qld_state_e device_state
);
   localparam logic [qld_pkg::OVC_W-1:0] OVC_LAST = qld_pkg::OVC_W'(OVL_FILT_CYC - 1);
   localparam logic [qld_pkg::OVC_W-1:0] OVC_ONE = qld_pkg::OVC_W'(1);

   qld_pkg::qld_core_s core_reg, core_next;
   qld_pkg::qld_rx_s rx_reg, rx_next;
   qld_pkg::qld_tx_s tx_reg, tx_next;
   qld_pkg::qld_pins_s pins_in;
   logic rx_run, tx_run, frame_clr, csb_rise, frame_ok, take;
   logic [7:0] stat;

   // ---------------------------------------------------------------
   // Serial side
   // ---------------------------------------------------------------
   // Chip select high clears the run flags, so each frame starts afresh
   // without needing a clock edge outside the frame.
   assign frame_clr = csb_n | rst;

   always_ff @(negedge sclk or posedge frame_clr) begin
      if (frame_clr) begin
         rx_run <= 1'b0;
      end else begin
         rx_run <= 1'b1;
      end
   end

   // The count saturates above sixteen and then steps round in eights, so even a
   // long daisy chain frame needs only five bits. The core reads the count and
   // the shift register only after the synchronised select rise, when the
   // serial clock is idle and both are stable.
   always_comb begin
      rx_next = rx_reg;
      rx_next.sh = {rx_reg.sh[qld_pkg::WORD_W-2:0], si};
      if (!rx_run) begin
         rx_next.cnt = 5'h01;
         rx_next.tgl = ~rx_reg.tgl;
      end else if (rx_reg.cnt[4]) begin
         // Past sixteen only the bit count modulo eight matters.
         rx_next.cnt = {2'h2, rx_reg.cnt[2:0] + 3'h1};
      end else begin
         rx_next.cnt = rx_reg.cnt + 5'h01;
      end
   end

   always_ff @(negedge sclk or posedge rst) begin
      if (rst) begin
         rx_reg <= '0;
      end else begin
         rx_reg <= rx_next;
      end
   end

   always_ff @(posedge sclk or posedge frame_clr) begin
      if (frame_clr) begin
         tx_run <= 1'b0;
      end else begin
         tx_run <= 1'b1;
      end
   end

   // The diagnostic word is frozen in the core domain while select is low,
   // so reading it here at the first rising edge is safe.
   always_comb begin
      tx_next = tx_reg;
      if (!tx_run) begin
         tx_next.sh = {qld_pkg::DIAG_PAD, core_reg.dw};
      end else begin
         tx_next.sh = {tx_reg.sh[qld_pkg::WORD_W-2:0], rx_reg.sh[0]};
      end
   end

   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         tx_reg <= '0;
      end else begin
         tx_reg <= tx_next;
      end
   end

   // Flag OR input lets an error ripple down a chain with no clocks.
   assign so = tx_run ? tx_reg.sh[qld_pkg::WORD_W-1] : (core_reg.ferr_h | si);
   assign so_oe_n = csb_n;

   // ---------------------------------------------------------------
   // Core side
   // ---------------------------------------------------------------
   // Every pin, and the frame toggle from the serial side, passes two flops in
   // the core domain before any decision reads it. This costs two cycles on every
   // mode change, which is far below any supply or pin timing.
   assign pins_in = '{lh: limp_home_input, en: enable, lpor: logic_por,
      apor: analog_por, csb: csb_n, tgl: rx_reg.tgl, pin: parallel_drive_inputs,
      ovl: overload_det, ot: overtemp_det, opn: open_load_det};

   assign csb_rise = core_reg.s2.csb & ~core_reg.csb_d;
   // A frame with no clocks leaves the toggle and the count alone, so it fails the toggle check.
   assign frame_ok = (core_reg.s2.tgl != core_reg.tgl_seen) && (rx_reg.cnt[2:0] == 3'h0)
      && rx_reg.cnt[4];

   always_comb begin
      logic do_rst;
      logic run;
      logic want;
      logic [1:0] m;
      do_rst = 1'b0;
      run = 1'b0;
      want = 1'b0;
      m = 2'h0;
      take = 1'b0;
      stat = 8'h00;
      core_next = core_reg;
      core_next.s1 = pins_in;
      core_next.s2 = core_reg.s1;
      core_next.csb_d = core_reg.s2.csb;
      // Priority: analog supply reset first, then limp home, which must also
      // override a logic supply reset, then the limp exit, and only then the
      // normal lockout, sleep and active flow.
      if (core_reg.s2.apor) begin
         core_next.st = qld_pkg::ST_LOCKOUT;
         do_rst = 1'b1;
      end else if (core_reg.s2.lh) begin
         core_next.st = qld_pkg::ST_LIMP;
      end else if (core_reg.st == qld_pkg::ST_LIMP) begin
         do_rst = 1'b1;
         core_next.st = core_reg.s2.en ? qld_pkg::ST_ACTIVE : qld_pkg::ST_SLEEP;
      end else if (core_reg.s2.lpor) begin
         core_next.st = qld_pkg::ST_LOCKOUT;
         do_rst = 1'b1;
      end else begin
         case (core_reg.st)
            qld_pkg::ST_LOCKOUT: begin
               core_next.st = core_reg.s2.en ? qld_pkg::ST_ACTIVE : qld_pkg::ST_SLEEP;
               core_next.ferr = 1'b1;
               core_next.nodiag = 1'b1;
            end
            qld_pkg::ST_SLEEP: begin
               if (core_reg.s2.en) begin
                  core_next.st = qld_pkg::ST_ACTIVE;
                  do_rst = 1'b1;
               end
            end
            qld_pkg::ST_ACTIVE: begin
               if (!core_reg.s2.en) begin
                  core_next.st = qld_pkg::ST_SLEEP;
                  do_rst = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      // One common reset path keeps every clear condition identical, at the
      // cost of also raising the frame flag when enable goes low.
      if (do_rst) begin
         core_next.cmd = qld_pkg::CMD_RST;
         core_next.olat = '0;
         core_next.otlat = '0;
         core_next.opn = '0;
         core_next.ovc = '0;
         core_next.nodiag = 1'b1;
         core_next.ferr = 1'b1;
      end
      if (csb_rise) begin
         core_next.tgl_seen = core_reg.s2.tgl;
         // Frames outside normal operation, limp home included, are dropped.
         if (core_reg.st == qld_pkg::ST_ACTIVE && core_next.st == qld_pkg::ST_ACTIVE) begin
            if (frame_ok) begin
               take = 1'b1;
               core_next.cmd = rx_reg.sh[qld_pkg::CMD_W-1:0];
               core_next.ferr = 1'b0;
               core_next.nodiag = 1'b0;
            end else begin
               core_next.ferr = 1'b1;
            end
         end
      end
      run = (core_next.st == qld_pkg::ST_ACTIVE) || (core_next.st == qld_pkg::ST_LIMP);
      for (int i = 0; i < qld_pkg::CH; i++) begin
         m = core_next.cmd[2*i +: 2];
         if (take && m == qld_pkg::CMD_STANDBY) begin
            core_next.olat[i] = 1'b0;
            core_next.otlat[i] = 1'b0;
            core_next.opn[i] = 1'b0;
            core_next.ovc[i] = '0;
         end
         if (core_next.st == qld_pkg::ST_LIMP) begin
            want = core_reg.s2.pin[i];
         end else begin
            want = (m == qld_pkg::CMD_ON) ||
               (m == qld_pkg::CMD_INPUT && core_reg.s2.pin[i]);
         end
         // Detection is applied after the clears so a new event wins.
         if (run) begin
            // The filter counts only while the driver is on; a spike shorter
            // than the filter time starts the count again.
            if (core_reg.drv[i] && core_reg.s2.ovl[i]) begin
               if (core_reg.ovc[i] == OVC_LAST) begin
                  core_next.olat[i] = 1'b1;
               end else begin
                  core_next.ovc[i] = core_reg.ovc[i] + OVC_ONE;
               end
            end else begin
               core_next.ovc[i] = '0;
            end
            if (core_reg.s2.ot[i]) begin
               core_next.otlat[i] = 1'b1;
            end
            if (!core_reg.drv[i] && core_reg.diag[i] && core_reg.s2.opn[i]) begin
               core_next.opn[i] = 1'b1;
            end
         end
         core_next.drv[i] = run && want && !core_next.olat[i] && !core_next.otlat[i];
         core_next.diag[i] = (core_next.st == qld_pkg::ST_ACTIVE) && !core_next.nodiag &&
            !core_next.drv[i] && (m == qld_pkg::CMD_OFF || m == qld_pkg::CMD_INPUT);
         // Status per channel: 00 ok, 01 open load, 10 overload, 11 overtemperature.
         // Overtemperature outranks overload, which in turn hides open load.
         stat[2*i+1] = core_next.olat[i] | core_next.otlat[i];
         stat[2*i] = core_next.otlat[i] | (core_next.opn[i] & ~core_next.olat[i]);
      end
      // Status is frozen for the whole frame so shifting sees a stable word.
      if (core_reg.s2.csb) begin
         core_next.dw = stat;
         core_next.ferr_h = core_next.ferr;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_reg <= '0;
         core_reg.cmd <= qld_pkg::CMD_RST;
         core_reg.nodiag <= 1'b1;
         core_reg.ferr <= 1'b1;
         core_reg.ferr_h <= 1'b1;
         // Select idles high, so the edge detector starts high to avoid a false rise.
         core_reg.s1.csb <= 1'b1;
         core_reg.s2.csb <= 1'b1;
         core_reg.csb_d <= 1'b1;
      end else begin
         core_reg <= core_next;
      end
   end

   assign driver_outputs = core_reg.drv;
   assign diag_current_en = core_reg.diag;
   assign device_state = core_reg.st;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // All checks run in the core domain; the serial side is covered by the
   // bench, which sees the link exactly as a controller would.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   logic [qld_pkg::CH-1:0] latv;
   assign latv = core_reg.olat | core_reg.otlat;

   chk_input_follow: assert property (
      (core_reg.st == qld_pkg::ST_ACTIVE && core_reg.cmd[5:4] == qld_pkg::CMD_INPUT
         && !latv[2]) |-> driver_outputs[2] == $past(core_reg.s2.pin[2]))
      else $error("input mode output does not follow its input");
   chk_limp_drive: assert property (
      (core_reg.st == qld_pkg::ST_LIMP) |-> driver_outputs == ($past(core_reg.s2.pin) & ~latv))
      else $error("limp home output differs from parallel inputs");
   chk_limp_cmd: assert property (
      (core_reg.st == qld_pkg::ST_LIMP) |-> $stable(core_reg.cmd))
      else $error("command changed during limp home");
   chk_limp_latch: assert property (
      (core_reg.st == qld_pkg::ST_LIMP && $past(core_reg.st) == qld_pkg::ST_LIMP)
         |-> ($past(latv) & ~latv) == '0 && (driver_outputs & latv) == '0)
      else $error("limp home shutoff released");
   chk_limp_exit: assert property (
      ($past(core_reg.st) == qld_pkg::ST_LIMP && (core_reg.st == qld_pkg::ST_ACTIVE
         || core_reg.st == qld_pkg::ST_SLEEP)) |-> core_reg.cmd == qld_pkg::CMD_RST
         && diag_current_en == '0 && core_reg.ferr)
      else $error("limp exit did not reset");
   chk_wake_flag: assert property (
      ($past(core_reg.st) == qld_pkg::ST_SLEEP && core_reg.st == qld_pkg::ST_ACTIVE)
         |-> core_reg.ferr && diag_current_en == '0 ##1 diag_current_en == '0)
      else $error("wake without frame flag or with diag current");
   chk_ot_channel: assert property (
      (core_next.st == qld_pkg::ST_ACTIVE && core_reg.s2.ot[2] && !core_reg.s2.ot[1]
         && !core_reg.otlat[1]) |=> core_reg.otlat[2] && !core_reg.otlat[1])
      else $error("overtemperature latch wrong channel");
   chk_ovl_filter: assert property (
      $rose(core_reg.olat[1]) |-> $past(core_reg.ovc[1]) == OVC_LAST
         && $past(driver_outputs[1]) ##0 !driver_outputs[1])
      else $error("overload latched without full filter");
   chk_open_off: assert property (
      $rose(core_reg.opn[2]) |-> !$past(driver_outputs[2]) && $past(diag_current_en[2]))
      else $error("open load flagged with driver on");
   chk_frame_bad: assert property (
      (csb_rise && core_reg.st == qld_pkg::ST_ACTIVE && core_next.st == qld_pkg::ST_ACTIVE
         && !frame_ok) |=> core_reg.ferr)
      else $error("bad frame not flagged");
   chk_frame_good: assert property (
      take |=> !core_reg.ferr && core_reg.cmd == $past(rx_reg.sh[7:0]))
      else $error("good frame not taken");
   chk_lockout_off: assert property (
      (core_reg.st == qld_pkg::ST_LOCKOUT) |-> driver_outputs == '0 && diag_current_en == '0)
      else $error("outputs active in lockout");
   chk_limp_por: assert property (
      (core_reg.st == qld_pkg::ST_LIMP && core_reg.s2.lh && !core_reg.s2.apor)
         |=> core_reg.st == qld_pkg::ST_LIMP)
      else $error("limp home left without analog reset");
   chk_sleep_clear: assert property (
      (core_reg.st == qld_pkg::ST_SLEEP) |-> latv == '0 && core_reg.opn == '0
         && driver_outputs == '0)
      else $error("faults or drive kept in deep sleep");
   chk_standby_clr: assert property (
      (take && core_next.cmd[3:2] == qld_pkg::CMD_STANDBY && !core_reg.s2.ot[1]
         && !core_reg.drv[1]) |=> !latv[1])
      else $error("standby did not clear channel faults");
   chk_cmd_hold: assert property (
      (!take && core_reg.st == qld_pkg::ST_ACTIVE && core_next.st == qld_pkg::ST_ACTIVE)
         |=> $stable(core_reg.cmd))
      else $error("command changed without a valid frame");

   cov_limp_entry: cover property ($rose(core_reg.st == qld_pkg::ST_LIMP));
   cov_good_frame: cover property (take);
   cov_ovl_latch: cover property ($rose(core_reg.olat[1]));
   cov_bad_frame: cover property (csb_rise && !frame_ok && core_reg.st == qld_pkg::ST_ACTIVE);
   cov_limp_exit: cover property ($fell(core_reg.st == qld_pkg::ST_LIMP));
endmodule

// [rtl/qld_pkg.sv]
// Purpose: Shared constants, types and state layouts of the quad driver control.
// Assumes: Core clock at 100 MHz.
// Notes: Channel command pairs sit in the low byte of each received word.
package qld_pkg;
   // ---------------------------------------------------------------
   // Geometry and timing
   // ---------------------------------------------------------------
   localparam int CH = 4;
   localparam int WORD_W = 16;
   localparam int CMD_W = 8;
   localparam int CLK_MHZ = 100;
   localparam int OVL_FILT_US = 3;
   localparam int OVL_FILT_CYC = OVL_FILT_US * CLK_MHZ;
   localparam int OVC_W = $clog2(OVL_FILT_CYC + 1);
   localparam int FRAME_MIN = 16;
   localparam int FRAME_STEP = 8;

   // ---------------------------------------------------------------
   // Commands, reset values and diagnostic pad
   // ---------------------------------------------------------------
   localparam logic [1:0] CMD_STANDBY = 2'h0;
   localparam logic [1:0] CMD_INPUT = 2'h1;
   localparam logic [1:0] CMD_ON = 2'h2;
   localparam logic [1:0] CMD_OFF = 2'h3;
   localparam logic [CMD_W-1:0] CMD_RST = 8'hff;
   localparam logic [7:0] DIAG_PAD = 8'h00;

   typedef enum logic [1:0] {
      ST_LOCKOUT,
      ST_SLEEP,
      ST_ACTIVE,
      ST_LIMP
   } qld_state_e;

   typedef struct packed {
      logic lh;
      logic en;
      logic lpor;
      logic apor;
      logic csb;
      logic tgl;
      logic [CH-1:0] pin;
      logic [CH-1:0] ovl;
      logic [CH-1:0] ot;
      logic [CH-1:0] opn;
   } qld_pins_s;

   typedef struct packed {
      qld_pins_s s1;
      qld_pins_s s2;
      logic csb_d;
      logic tgl_seen;
      qld_state_e st;
      logic [CMD_W-1:0] cmd;
      logic nodiag;
      logic ferr;
      logic [CH-1:0] olat;
      logic [CH-1:0] otlat;
      logic [CH-1:0] opn;
      logic [CH-1:0] drv;
      logic [CH-1:0] diag;
      logic [CH-1:0][OVC_W-1:0] ovc;
      logic [7:0] dw;
      logic ferr_h;
   } qld_core_s;

   typedef struct packed {
      logic [4:0] cnt;
      logic [WORD_W-1:0] sh;
      logic tgl;
   } qld_rx_s;

   typedef struct packed {
      logic [WORD_W-1:0] sh;
   } qld_tx_s;
endpackage

// [tb/qld_spi_master.sv]
// Purpose: Serial master model for the quad driver control.
// Assumes: Link clock of 15 ns that only runs inside a frame.
// Notes: Input is changed on rising clock edges, so it never races the falling sample.
`timescale 1ns/10ps
module qld_spi_master (
   output logic sclk,
   output logic csb_n,
   output logic si,
   input wire logic so
);
   initial begin
      sclk = 1'b0;
      csb_n = 1'b1;
      si = 1'b1;
   end

   // ---------------------------------------------------------------
   // One frame of n bits; rd holds the last n bits seen on so
   // ---------------------------------------------------------------
   task automatic xfer(input int n, input logic [31:0] w, input logic si0,
         output logic flag, output logic [31:0] rd);
      rd = '0;
      csb_n = 1'b0;
      si = si0;
      #60;
      flag = so;
      for (int i = 0; i < n; i++) begin
         sclk = 1'b1;
         si = w[n-1-i];
         #7.5;
         rd = {rd[30:0], so};
         sclk = 1'b0;
         #7.5;
      end
      #20;
      csb_n = 1'b1;
      // A deselected line must not keep showing the last bit.
      si = ~si;
      #2000;
   endtask
endmodule

// [tb/tb_top.sv]
// Purpose: Self-checking bench of the quad driver control.
// Assumes: Overload filter shortened to 4 core cycles.
// Notes: Pins change on the falling core clock edge.
`timescale 1ns/10ps
module tb_top;
   logic clk, rst, sclk, csb_n, si, so, so_oe_n, limp, en, lpor, apor, flag;
   logic [3:0] pdi, ovl, ot, opn, drv, dcur;
   logic [31:0] rd;
   qld_pkg::qld_state_e st;
   int fail_count = 0;
   int checks_done = 0;
   int n_tab[6] = '{15, 17, 8, 24, 32, 16};
   logic [31:0] w_tab[6] = '{32'haa, 32'haa, 32'haa, 32'h2, 32'h1234_0008, 32'haa};
   logic [3:0] o_tab[6] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h2, 4'hf};
   logic f_tab[6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

   always #5 clk = ~clk;

   qld_ctrl #(.OVL_FILT_CYC(4)) u_dut (.clk(clk), .rst(rst), .sclk(sclk), .csb_n(csb_n),
      .si(si), .so(so), .so_oe_n(so_oe_n), .limp_home_input(limp), .enable(en),
      .logic_por(lpor), .analog_por(apor), .parallel_drive_inputs(pdi),
      .overload_det(ovl), .overtemp_det(ot), .open_load_det(opn), .driver_outputs(drv),
      .diag_current_en(dcur), .device_state(st));

   qld_spi_master u_mst (.sclk(sclk), .csb_n(csb_n), .si(si), .so(so));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t ns %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic frame(input int n, input logic [31:0] w);
      u_mst.xfer(n, w, 1'b0, flag, rd);
      tick(1);
   endtask

   task automatic wait_state(input qld_pkg::qld_state_e s);
      for (int i = 0; i < 40 && st !== s; i++) @(negedge clk);
      check(st, s, "state");
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      #500us;
      fail_count++;
      $display("[FAIL] %0t ns watchdog expired", $time);
      finish_test();
   end

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {limp, lpor, apor, pdi, ovl, ot, opn} = '0;
      en = 1'b1;
      tick(16);
      rst = 1'b0;
      wait_state(qld_pkg::ST_ACTIVE);
      check(so_oe_n, 1'b1, "idle so enable");
      frame(0, 32'h0);
      check(flag, 1'b1, "flag after power up");
      check(dcur, 4'h0, "no diag at power up");
      frame(16, 32'haa);
      check(drv, 4'hf, "all on");
      frame(16, 32'haa);
      check(flag, 1'b0, "flag cleared");
      $display("test power_up done");

      pdi = 4'h4;
      frame(16, 32'h5ad8);
      check(drv, 4'h6, "mixed modes");
      check(dcur, 4'h8, "diag in off mode");
      pdi = 4'h0;
      opn = 4'h4;
      tick(25100);
      check(drv, 4'h2, "input follows");
      check(dcur, 4'hc, "diag in input mode off");
      opn = 4'h0;
      frame(16, 32'hd8);
      check(rd[15:0], 16'h0010, "open load status");
      $display("test modes done");

      frame(16, 32'hff);
      for (int k = 0; k < 6; k++) begin
         frame(n_tab[k], w_tab[k]);
         check(drv, o_tab[k], "frame length data");
         if (n_tab[k] == 32) check(rd[15:0], 16'h1234, "daisy pass");
         frame(0, 32'h0);
         check(flag, f_tab[k], "frame length flag");
      end
      frame(16, 32'haa);
      u_mst.xfer(0, 32'h0, 1'b1, flag, rd);
      check(flag, 1'b1, "flag or input");
      $display("test framing done");

      frame(16, 32'h0);
      frame(16, 32'hea);
      check(drv, 4'h7, "three on");
      ovl = 4'h2;
      tick(2);
      ovl = 4'h0;
      tick(10);
      check(drv, 4'h7, "short overload ignored");
      ovl = 4'h2;
      ot = 4'h4;
      opn = 4'h9;
      tick(8);
      {ovl, ot, opn} = '0;
      tick(10);
      check(drv, 4'h1, "faulted channels off");
      frame(16, 32'hea);
      check(rd[15:0], 16'h0078, "fault status");
      check(drv, 4'h1, "latch holds");
      frame(16, 32'hc2);
      frame(16, 32'hea);
      check(drv, 4'h7, "cleared channels on");
      check(rd[15:0], 16'h0040, "per channel clear");
      $display("test faults done");

      pdi = 4'ha;
      limp = 1'b1;
      tick(10);
      check(st, qld_pkg::ST_LIMP, "limp entry");
      check(drv, 4'ha, "limp drive");
      frame(16, 32'h0);
      check(drv, 4'ha, "limp ignores command");
      ovl = 4'h2;
      tick(8);
      ovl = 4'h0;
      lpor = 1'b1;
      tick(10);
      check(drv, 4'h8, "limp overload off");
      check(st, qld_pkg::ST_LIMP, "logic reset ignored");
      lpor = 1'b0;
      tick(10);
      frame(16, 32'h0);
      check(rd[15:0], 16'h0048, "limp fault kept");
      limp = 1'b0;
      tick(10);
      check(st, qld_pkg::ST_ACTIVE, "limp exit");
      check({drv, dcur}, 8'h00, "limp exit off");
      frame(16, 32'hff);
      check(flag, 1'b1, "flag after limp");
      check(rd[15:0], 16'h0000, "faults cleared");
      $display("test limp done");

      en = 1'b0;
      tick(10);
      check(st, qld_pkg::ST_SLEEP, "sleep");
      en = 1'b1;
      tick(10);
      check(st, qld_pkg::ST_ACTIVE, "wake");
      frame(0, 32'h0);
      check(flag, 1'b1, "flag after wake");
      pdi = 4'hf;
      limp = 1'b1;
      tick(10);
      apor = 1'b1;
      tick(10);
      check(drv, 4'h0, "analog reset off");
      {apor, limp, pdi} = '0;
      wait_state(qld_pkg::ST_ACTIVE);
      $display("test supplies done");
      finish_test();
   end
endmodule
